// ### hdl/conv_seq.sv
// Purpose: conversion sequencer, sleep / temperature / humidity phases
// Assumes: start only while asleep, abort wins over everything
// Notes: durations per resolution are parameters
`timescale 1ns/1ps
`include "htm_params.svh"
module conv_seq #(
    parameter int CONV14_CYC = `HTM_NS2CYC(`HTM_CONV14_NS),
    parameter int CONV11_CYC = `HTM_NS2CYC(`HTM_CONV11_NS),
    parameter int CONV8_CYC = `HTM_NS2CYC(`HTM_CONV8_NS)
) (
    input wire logic i_mclk,        // system clock
    input wire logic i_resetn,      // async reset, active low
    input wire logic i_start,       // trigger pulse
    input wire logic i_both,        // temperature then humidity
    input wire logic i_humid,       // single humidity conversion
    input wire logic i_abort,       // abort pulse
    input wire logic i_tres,        // temperature resolution select
    input wire logic [1:0] i_hres,  // humidity resolution select
    output logic o_busy,            // measurement state
    output logic o_temp_done,       // temperature finished pulse
    output logic o_humid_done       // humidity finished pulse
);
    htm_pkg::conv_state_t st_r;
    logic [15:0] cnt_r;
    logic both_r;

    function automatic logic [15:0] dur(input logic [1:0] res);
        case (res)
            2'h0: dur = 16'(CONV14_CYC - 1);
            2'h1: dur = 16'(CONV11_CYC - 1);
            default: dur = 16'(CONV8_CYC - 1);
        endcase
    endfunction

    wire [15:0] temp_len = dur({1'b0, i_tres});
    wire [15:0] humid_len = dur(i_hres);
    wire cnt_end = (cnt_r == 16'h0000);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= htm_pkg::C_SLEEP;
            cnt_r <= 16'h0000;
            both_r <= 1'b0;
            o_temp_done <= 1'b0;
            o_humid_done <= 1'b0;
        end else begin
            o_temp_done <= 1'b0;
            o_humid_done <= 1'b0;
            if (i_abort) begin
                st_r <= htm_pkg::C_SLEEP;
            end else begin
                case (st_r)
                    htm_pkg::C_SLEEP: begin
                        if (i_start) begin
                            both_r <= i_both;
                            st_r <= (i_humid && !i_both) ? htm_pkg::C_HUMID : htm_pkg::C_TEMP;
                            cnt_r <= (i_humid && !i_both) ? humid_len : temp_len;
                        end
                    end
                    htm_pkg::C_TEMP: begin
                        if (cnt_end) begin
                            o_temp_done <= 1'b1;
                            st_r <= both_r ? htm_pkg::C_HUMID : htm_pkg::C_SLEEP;
                            cnt_r <= humid_len;
                        end else begin
                            cnt_r <= cnt_r - 16'h0001;
                        end
                    end
                    htm_pkg::C_HUMID: begin
                        if (cnt_end) begin
                            o_humid_done <= 1'b1;
                            st_r <= htm_pkg::C_SLEEP;
                        end else begin
                            cnt_r <= cnt_r - 16'h0001;
                        end
                    end
                    default: st_r <= htm_pkg::C_SLEEP;
                endcase
            end
        end
    end

    assign o_busy = (st_r != htm_pkg::C_SLEEP);
endmodule // conv_seq

// ### hdl/htm_params.svh
// Purpose: offsets, field positions, reset values and timing of the humidity/temperature controller
// Assumes: 50 MHz system clock
// Notes: included by the conversion sequencer and the controller design files of the block
`ifndef HTM_PARAMS_SVH
`define HTM_PARAMS_SVH

`define HTM_DEV_ADDR 7'h40
`define HTM_PTR_TEMP 8'h00
`define HTM_PTR_HUMID 8'h01
`define HTM_PTR_CFG 8'h02
`define HTM_PTR_RSV_LO 8'h03
`define HTM_PTR_RSV_HI 8'hFA
`define HTM_PTR_UID0 8'hFB
`define HTM_PTR_UID1 8'hFC
`define HTM_PTR_UID2 8'hFD
`define HTM_PTR_MAKER 8'hFE
`define HTM_PTR_PART 8'hFF

`define HTM_PTR_RST 8'h00
`define HTM_RESULT_RST 16'h0000
`define HTM_CFG_RST 16'h1000
`define HTM_CFG_WMASK 16'h1700
`define HTM_CFG_MODE_BIT 12
`define HTM_CFG_TRES_BIT 10
`define HTM_CFG_HRES_HI 9
`define HTM_CFG_HRES_LO 8

`define HTM_CLK_NS 20
`define HTM_CONV14_NS 6400
`define HTM_CONV11_NS 3800
`define HTM_CONV8_NS 2600
`define HTM_NS2CYC(ns) (((ns) + `HTM_CLK_NS - 1) / `HTM_CLK_NS)

`endif

// ### hdl/htm_pkg.sv
// Purpose: shared types of the humidity/temperature controller
// Assumes: nothing
// Notes: constants live in htm_params.svh
package htm_pkg;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} bus_state_t;
    typedef enum logic [1:0] {C_SLEEP, C_TEMP, C_HUMID} conv_state_t;
endpackage

// ### hdl/humidity_temp_measure_ctrl.sv
// Purpose: two-wire target, register map and measurement control of a humidity/temperature sensor
// Assumes: pins sampled by i_mclk; converter codes valid when a done pulse fires
// Notes: data pin is open drain, only ever pulled low
`timescale 1ns/1ps
`include "htm_params.svh"
module humidity_temp_measure_ctrl #(
    parameter int CONV14_CYC = `HTM_NS2CYC(`HTM_CONV14_NS),
    parameter int CONV11_CYC = `HTM_NS2CYC(`HTM_CONV11_NS),
    parameter int CONV8_CYC = `HTM_NS2CYC(`HTM_CONV8_NS),
    parameter logic [15:0] UID_FIRST = 16'h1234, // arbitrary value
    parameter logic [15:0] UID_MID = 16'h5678,   // arbitrary value
    parameter logic [15:0] UID_LAST = 16'h9A00,  // arbitrary value
    parameter logic [15:0] MAKER_ID = 16'hA5C3,  // arbitrary value
    parameter logic [15:0] PART_ID = 16'h0C3A    // arbitrary value
) (
    input wire logic i_mclk,              // system clock, 50 MHz
    input wire logic i_resetn,            // async power-on reset, active low
    input wire logic i_scl,               // serial clock pin
    input wire logic i_sda,               // serial data pin level
    output logic o_sda_out,               // serial data drive value, always low
    output logic o_sda_oe_n,              // serial data enable, low pulls the pin
    input wire logic [13:0] i_temp_code,  // temperature converter code
    input wire logic [13:0] i_humid_code, // humidity converter code
    output logic o_measuring              // measurement state
);
    htm_pkg::bus_state_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r, ptr_r, msb_r, rd_cnt_r;
    logic [15:0] cfg_r, temp_r, humid_r;
    logic addr_ph_r, rw_r, ack_r, ptr_only_r, sda_oe_n_r, sda_out_r;
    logic temp_ok_r, humid_ok_r, meas_r, both_r;
    logic [1:0] wb_r;
    logic sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    logic busy, temp_done, humid_done;

    function automatic logic is_result(input logic [7:0] p);
        is_result = (p == `HTM_PTR_TEMP) || (p == `HTM_PTR_HUMID);
    endfunction

    function automatic logic [15:0] reg_word(input logic [7:0] a);
        case (a)
            `HTM_PTR_TEMP: reg_word = temp_r;
            `HTM_PTR_HUMID: reg_word = humid_r;
            `HTM_PTR_CFG: reg_word = cfg_r;
            `HTM_PTR_UID0: reg_word = UID_FIRST;
            `HTM_PTR_UID1: reg_word = UID_MID;
            `HTM_PTR_UID2: reg_word = UID_LAST;
            `HTM_PTR_MAKER: reg_word = MAKER_ID;
            `HTM_PTR_PART: reg_word = PART_ID;
            default: reg_word = 16'h0000;
        endcase
    endfunction

    i2c_pin_sync u_pins (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda(sda_s),
        .o_scl_rise(scl_rise),
        .o_scl_fall(scl_fall),
        .o_start(bus_start),
        .o_stop(bus_stop)
    );

    // bus decode
    wire mode_both = cfg_r[`HTM_CFG_MODE_BIT];
    wire byte_end = (st_r == htm_pkg::S_RX) && scl_fall && (cnt_r == 4'h8);
    wire [7:0] rx_byte = sh_r;
    wire addr_hit = (rx_byte[7:1] == `HTM_DEV_ADDR);
    wire ptr_legal = !((rx_byte >= `HTM_PTR_RSV_LO) && (rx_byte <= `HTM_PTR_RSV_HI));
    wire temp_rdy = temp_ok_r && (!mode_both || humid_ok_r);
    wire rd_ready = (ptr_r == `HTM_PTR_TEMP) ? temp_rdy :
                    (ptr_r == `HTM_PTR_HUMID) ? humid_ok_r : 1'b1;
    wire ack_addr = addr_hit && (!rx_byte[0] || rd_ready);
    wire ack_data = (wb_r == 2'h0) ? ptr_legal : (ptr_r == `HTM_PTR_CFG);
    wire ack_now = addr_ph_r ? ack_addr : ack_data;
    wire wr_byte = byte_end && !addr_ph_r;
    wire cfg_we = wr_byte && (wb_r == 2'h2) && (ptr_r == `HTM_PTR_CFG);
    wire conv_abort = wr_byte && (wb_r == 2'h0) && is_result(rx_byte) && busy;
    wire trig = (bus_start || bus_stop) && ptr_only_r;
    wire trig_humid = (ptr_r == `HTM_PTR_HUMID);
    wire [7:0] rd_addr = ptr_r + {1'b0, rd_cnt_r[7:1]};
    wire [15:0] rd_word = reg_word(rd_addr);
    wire [7:0] tx_byte = rd_cnt_r[0] ? rd_word[7:0] : rd_word[15:8];

    conv_seq #(
        .CONV14_CYC(CONV14_CYC),
        .CONV11_CYC(CONV11_CYC),
        .CONV8_CYC(CONV8_CYC)
    ) u_conv (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_start(trig),
        .i_both(mode_both),
        .i_humid(trig_humid),
        .i_abort(conv_abort),
        .i_tres(cfg_r[`HTM_CFG_TRES_BIT]),
        .i_hres(cfg_r[`HTM_CFG_HRES_HI:`HTM_CFG_HRES_LO]),
        .o_busy(busy),
        .o_temp_done(temp_done),
        .o_humid_done(humid_done)
    );

    // byte-level target state machine
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= htm_pkg::S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            addr_ph_r <= 1'b0;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            wb_r <= 2'h0;
            rd_cnt_r <= 8'h00;
            sda_oe_n_r <= 1'b1;
        end else if (bus_start) begin
            st_r <= htm_pkg::S_RX;
            cnt_r <= 4'h0;
            addr_ph_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else if (bus_stop) begin
            st_r <= htm_pkg::S_IDLE;
            sda_oe_n_r <= 1'b1;
        end else begin
            case (st_r)
                htm_pkg::S_IDLE: begin
                    sda_oe_n_r <= 1'b1;
                end
                htm_pkg::S_RX: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        st_r <= htm_pkg::S_RX_ACK;
                        sda_oe_n_r <= !ack_now;
                        ack_r <= ack_now;
                        cnt_r <= 4'h0;
                        if (addr_ph_r) begin
                            rw_r <= rx_byte[0];
                            rd_cnt_r <= 8'h00;
                        end
                    end
                end
                htm_pkg::S_RX_ACK: begin
                    if (scl_fall) begin
                        if (!ack_r) begin
                            st_r <= htm_pkg::S_IDLE;
                            sda_oe_n_r <= 1'b1;
                        end else if (addr_ph_r && rw_r) begin
                            st_r <= htm_pkg::S_TX;
                            tx_r <= tx_byte;
                            sda_oe_n_r <= tx_byte[7];
                        end else begin
                            st_r <= htm_pkg::S_RX;
                            sda_oe_n_r <= 1'b1;
                            wb_r <= addr_ph_r ? 2'h0 : ((wb_r == 2'h3) ? wb_r : wb_r + 2'h1);
                        end
                        addr_ph_r <= 1'b0;
                    end
                end
                htm_pkg::S_TX: begin
                    if (scl_rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == 4'h8) begin
                            st_r <= htm_pkg::S_TX_ACK;
                            sda_oe_n_r <= 1'b1;
                            rd_cnt_r <= rd_cnt_r + 8'h01;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_n_r <= tx_r[6];
                        end
                    end
                end
                htm_pkg::S_TX_ACK: begin
                    if (scl_rise) begin
                        ack_r <= !sda_s;
                    end else if (scl_fall) begin
                        st_r <= ack_r ? htm_pkg::S_TX : htm_pkg::S_IDLE;
                        tx_r <= tx_byte;
                        sda_oe_n_r <= ack_r ? tx_byte[7] : 1'b1;
                        cnt_r <= 4'h0;
                    end
                end
                default: st_r <= htm_pkg::S_IDLE;
            endcase
        end
    end

    // pointer and configuration
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr_r <= `HTM_PTR_RST;
            cfg_r <= `HTM_CFG_RST;
            msb_r <= 8'h00;
        end else if (wr_byte && ack_data) begin
            if (wb_r == 2'h0) begin
                ptr_r <= rx_byte;
            end
            if (wb_r == 2'h1) begin
                msb_r <= rx_byte;
            end
            if (cfg_we) begin
                cfg_r <= {msb_r, rx_byte} & `HTM_CFG_WMASK;
            end
        end
    end

    // pointer-only write detection, trigger at end of transaction
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr_only_r <= 1'b0;
        end else if (bus_start || bus_stop) begin
            ptr_only_r <= 1'b0;
        end else if (wr_byte) begin
            ptr_only_r <= (wb_r == 2'h0) && ptr_legal && is_result(rx_byte);
        end
    end

    // results and their updated flags; a done pulse wins over a clear
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            temp_r <= `HTM_RESULT_RST;
            humid_r <= `HTM_RESULT_RST;
            temp_ok_r <= 1'b0;
            humid_ok_r <= 1'b0;
            both_r <= 1'b0;
        end else begin
            if (temp_done) begin
                temp_r <= {i_temp_code, 2'h0};
                temp_ok_r <= 1'b1;
            end else if (trig && (mode_both || !trig_humid)) begin
                temp_ok_r <= 1'b0;
            end
            if (humid_done) begin
                humid_r <= {i_humid_code, 2'h0};
                humid_ok_r <= 1'b1;
            end else if (trig && (mode_both || trig_humid)) begin
                humid_ok_r <= 1'b0;
            end
            if (trig) begin
                both_r <= mode_both;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            meas_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else begin
            meas_r <= busy;
            sda_out_r <= 1'b0;
        end
    end

    assign o_measuring = meas_r;
    assign o_sda_oe_n = sda_oe_n_r;
    assign o_sda_out = sda_out_r;

    // busy cycles of the current run, for the bounded-return check
    logic [15:0] run_len_r;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            run_len_r <= 16'h0000;
        end else begin
            run_len_r <= busy ? run_len_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    ptr_reset_a: assert property ($rose(i_resetn) |-> ptr_r == `HTM_PTR_RST)
        else $error("pointer not zero after reset");
    result_lsb_a: assert property (temp_r[1:0] == 2'h0 && humid_r[1:0] == 2'h0)
        else $error("result low bits not zero");
    temp_first_a: assert property (temp_done && both_r |=> busy ##1 !temp_done)
        else $error("combined sequence did not go on to humidity");
    trig_start_a: assert property (trig && !busy |=> busy)
        else $error("trigger did not start a conversion");
    sleep_only_a: assert property ($rose(busy) |-> $past(trig))
        else $error("conversion started without trigger");
    abort_conv_a: assert property (conv_abort |=> !busy ##1 !busy)
        else $error("write to result did not abort");
    nack_notready_a: assert property (byte_end && addr_ph_r && addr_hit && rx_byte[0] && !rd_ready
        |=> sda_oe_n_r && st_r == htm_pkg::S_RX_ACK)
        else $error("read of stale result acknowledged");
    nack_unused_a: assert property (wr_byte && wb_r == 2'h0 && !ptr_legal |=> sda_oe_n_r ##1 ptr_r == $past(ptr_r, 2))
        else $error("unused pointer acknowledged or loaded");
    addr_match_a: assert property (byte_end && addr_ph_r && !addr_hit |=> sda_oe_n_r)
        else $error("foreign address acknowledged");
    msb_order_a: assert property (st_r == htm_pkg::S_TX && scl_fall && cnt_r != 4'h8
        |=> sda_oe_n_r == $past(tx_r[6]))
        else $error("transmit bit order wrong");
    cfg_keep_a: assert property (!cfg_we |=> cfg_r == $past(cfg_r))
        else $error("configuration changed without write");
    result_rst_a: assert property ($rose(i_resetn) |->
        temp_r == `HTM_RESULT_RST && humid_r == `HTM_RESULT_RST)
        else $error("result not zero after reset");
    temp_latch_a: assert property (temp_done |=> temp_r == {$past(i_temp_code), 2'h0})
        else $error("temperature code not latched");
    humid_latch_a: assert property (humid_done |=> humid_r == {$past(i_humid_code), 2'h0})
        else $error("humidity code not latched");
    ptr_load_a: assert property (wr_byte && wb_r == 2'h0 && ptr_legal |=> ptr_r == $past(rx_byte))
        else $error("pointer not loaded by write");
    ro_nack_a: assert property (wr_byte && wb_r != 2'h0 && ptr_r != `HTM_PTR_CFG |=> sda_oe_n_r)
        else $error("data to read-only register acknowledged");
    sleep_return_a: assert property (run_len_r <= 16'(2 * CONV14_CYC))
        else $error("measurement did not return to sleep");

    cover property (trig && mode_both);
    cover property (trig && !mode_both && trig_humid);
    cover property (conv_abort);
    cover property (st_r == htm_pkg::S_TX_ACK && scl_fall && ack_r && rd_cnt_r == 8'h03);
    cover property (byte_end && addr_ph_r && addr_hit && rx_byte[0] && !rd_ready);
endmodule // humidity_temp_measure_ctrl

// ### hdl/i2c_pin_sync.sv
// Purpose: synchronise the serial clock and data pins and find edges, start and stop
// Assumes: serial clock much slower than i_mclk
// Notes: first stage flops feed only the second stage
`timescale 1ns/1ps
module i2c_pin_sync (
    input wire logic i_mclk,      // system clock
    input wire logic i_resetn,    // async reset, active low
    input wire logic i_scl,       // serial clock pin
    input wire logic i_sda,       // serial data pin
    output logic o_sda,           // synchronised data
    output logic o_scl_rise,      // serial clock rising edge
    output logic o_scl_fall,      // serial clock falling edge
    output logic o_start,         // start condition
    output logic o_stop           // stop condition
);
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= i_scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= i_sda;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    assign o_sda = sda_s_r;
    assign o_scl_rise = scl_s_r & ~scl_d_r;
    assign o_scl_fall = ~scl_s_r & scl_d_r;
    assign o_start = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
    assign o_stop = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
endmodule // i2c_pin_sync

// ### tb/humidity_temp_measure_ctrl_tb_top.sv
// Purpose: self-checking bench of the humidity/temperature controller
// Assumes: short conversion parameters for simulation
// Notes: random configs and codes from a fixed-seed xorshift
`timescale 1ns/1ps
module humidity_temp_measure_ctrl_tb_top;
    localparam int C14 = 400;
    localparam int C11 = 200;
    localparam int C8 = 100;
    localparam logic [4:0][15:0] IDS = {16'h6677, 16'h4455, 16'h3300, 16'h2222, 16'h1111}; // arbitrary values
    logic i_mclk, i_resetn, scl, m_rel, sda, oe_n, sda_o, o_measuring;
    logic [13:0] tc, hc;
    logic [31:0] seed = 32'hC5B0;
    int error_cnt = 0, tests_run = 0, run_cnt = 0, last_run = 0;
    assign sda = (oe_n | sda_o) & m_rel;
    i2c_master_model u_m (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_rel(m_rel));
    humidity_temp_measure_ctrl #(.CONV14_CYC(C14), .CONV11_CYC(C11), .CONV8_CYC(C8),
        .UID_FIRST(IDS[0]), .UID_MID(IDS[1]), .UID_LAST(IDS[2]), .MAKER_ID(IDS[3]), .PART_ID(IDS[4])
    ) u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o),
        .o_sda_oe_n(oe_n), .i_temp_code(tc), .i_humid_code(hc), .o_measuring(o_measuring));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (o_measuring === 1'b1) run_cnt <= run_cnt + 1;
        else if (run_cnt != 0) begin
            last_run <= run_cnt;
            run_cnt <= 0;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_len(input logic [15:0] c, input logic [7:0] p);
        int t, h;
        t = c[10] ? C11 : C14;
        h = (c[9:8] == 2'b00) ? C14 : (c[9:8] == 2'b01) ? C11 : C8;
        return c[12] ? t + h : (p[0] ? h : t);
    endfunction
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (8) @(posedge i_mclk);
        while (o_measuring === 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            end_of_test();
        end
        repeat (2) @(posedge i_mclk);
    endtask
    task automatic frame_w(input logic [7:0] p, input logic wd, input logic [15:0] v, output logic ok);
        logic a;
        u_m.start();
        u_m.wr_byte(8'h80, ok);
        u_m.wr_byte(p, a);
        ok = ok & a;
        if (wd) begin
            u_m.wr_byte(v[15:8], a);
            ok = ok & a;
            u_m.wr_byte(v[7:0], a);
            ok = ok & a;
        end
        u_m.stop();
    endtask
    task automatic frame_r(input int n, output logic ok, output logic [31:0] d);
        logic [7:0] b;
        d = '0;
        u_m.start();
        u_m.wr_byte(8'h81, ok);
        for (int i = 0; i < n && ok; i++) begin
            u_m.rd_byte(i == n - 1, b);
            d = {d[23:0], b};
        end
        u_m.stop();
    endtask
    initial begin
        logic ok;
        logic [31:0] d, r, e;
        logic [15:0] cfg;
        logic [7:0] p;
        i_resetn = 1'b0;
        tc = '0;
        hc = '0;
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk("measuring", o_measuring, 0);
        frame_r(2, ok, d);
        chk("nack_unread", ok, 0);
        frame_w(8'h02, 1'b0, 16'h0000, ok);
        frame_r(2, ok, d);
        chk("cfg_rst", {ok, d}, {1'b1, 32'h1000});
        r = rnd();
        frame_w(8'h03 + r[7:0] % 8'hF8, 1'b0, 16'h0000, ok);
        chk("rsv_ptr", ok, 0);
        u_m.start();
        u_m.wr_byte({7'h40 ^ (r[14:8] | 7'h01), r[15]}, ok);
        u_m.stop();
        chk("foreign_addr", ok, 0);
        frame_w(8'hFE, 1'b1, 16'h0000, ok);
        chk("ro_write", ok, 0);
        for (int i = 0; i < 5; i++) begin
            frame_w(8'hFB + 8'(i), 1'b0, 16'h0000, ok);
            frame_r(2, ok, d);
            chk("id_word", {ok, d}, {1'b1, 16'h0000, IDS[i]});
        end
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            cfg = {3'b000, k[0], 1'b0, r[1], r[3:2], 8'h00};
            p = k[0] ? 8'h00 : {7'd0, k[1]};
            tc <= r[31:18];
            hc <= r[17:4];
            e = k[0] ? {r[31:18], 2'b00, r[17:4], 2'b00} : {16'h0000, p[0] ? r[17:4] : r[31:18], 2'b00};
            frame_w(8'h02, 1'b1, cfg, ok);
            frame_w(p, 1'b0, 16'h0000, ok);
            wait_idle();
            chk("conv_len", last_run, exp_len(cfg, p));
            frame_r(k[0] ? 4 : 2, ok, d);
            chk("result", {ok, d}, {1'b1, e});
            frame_w(8'h02, 1'b0, 16'h0000, ok);
            frame_r(2, ok, d);
            chk("cfg_keep", {ok, d}, {1'b1, 16'h0000, cfg});
        end
        frame_w(8'h02, 1'b1, 16'h1000, ok);
        frame_w(8'h00, 1'b0, 16'h0000, ok);
        frame_r(2, ok, d);
        chk("busy_read", ok, 0);
        wait_idle();
        chk("undisturbed", last_run, 2 * C14);
        frame_w(8'h00, 1'b0, 16'h0000, ok);
        frame_w(8'h01, 1'b0, 16'h0000, ok);
        chk("aborted", last_run < 2 * C14, 1);
        wait_idle();
        chk("retrigger", last_run, 2 * C14);
        end_of_test();
    end
endmodule // humidity_temp_measure_ctrl_tb_top

// ### tb/i2c_master_model.sv
// Purpose: two-wire bus master model driving the sensor target
// Assumes: one bit per 8 i_mclk cycles, 160 ns clock period
// Notes: clock stands high between frames; released data line reads high
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic i_mclk, // system clock
    input wire logic i_sda,  // resolved data wire
    output logic o_scl,      // serial clock
    output logic o_sda_rel   // low pulls data line
);
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // data changes mid-low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        w(2);
        o_sda_rel <= b;
        w(2);
        o_scl <= 1'b1;
        w(2);
        r = i_sda;
        w(2);
        o_scl <= 1'b0;
    endtask
    task automatic start();
        w(2);
        o_sda_rel <= 1'b1;
        w(2);
        o_scl <= 1'b1;
        w(4);
        o_sda_rel <= 1'b0;
        w(4);
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        w(2);
        o_sda_rel <= 1'b0;
        w(2);
        o_scl <= 1'b1;
        w(4);
        o_sda_rel <= 1'b1;
        w(4);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule // i2c_master_model
